/* File: hw/sld_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sld_top
  import sld_pkg::*;
#(
  parameter int unsigned WIDTH = SLD_WIDTH
) (
  input  wire logic             clk,     // system clock, 250 MHz
  input  wire logic             rst_n,   // async reset, active low
  input  wire logic             sclk,    // serial clock from controller
  input  wire logic             sdin,    // serial data in
  input  wire logic             strobe,  // latch transfer, high = open
  input  wire logic             blank,   // blanking, high = all off
  output var  logic             sdout,   // serial data out, cascade
  output var  logic [WIDTH-1:0] src_on,  // source driver enables
  output var  logic [WIDTH-1:0] pd_on    // pull-down sink enables
);

  // ----------------------------------------------------------------------
  // serial clock edge detect
  // ----------------------------------------------------------------------
  // inputs are synchronous to clk, so no synchroniser is needed here
  // the detector idles low like the pin, so a release with the serial
  // clock low raises no false edge
  logic sclk_q;
  logic sclk_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  assign sclk_rise = sclk & ~sclk_q;

  // ----------------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------------
  // first bit in walks to the top stage after one rise per stage
  logic [WIDTH-1:0] sreg_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sreg_q <= WIDTH'(SLD_RST_ZERO);
    end else if (sclk_rise) begin
      sreg_q <= {sreg_q[WIDTH-2:0], sdin};
    end
  end

  // last stage is itself a flop, so it goes out directly
  assign sdout = sreg_q[WIDTH-1];

  // ----------------------------------------------------------------------
  // latches
  // ----------------------------------------------------------------------
  // transparency is emulated by a clocked copy; it lags one cycle,
  // far below the serial clock period, so the effect is the same
  logic [WIDTH-1:0] latch_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= WIDTH'(SLD_RST_ZERO);
    end else if (strobe) begin
      latch_q <= sreg_q;
    end
  end
  // strobe low: no load path, contents held; blanking does not stop a load while strobe is high

  // ----------------------------------------------------------------------
  // drive decode
  // ----------------------------------------------------------------------
  // source and sink of one output are always opposite: one decode feeds
  // both registers, so an output is never driven high and pulled low at
  // once, nor left floating between the two
  function automatic logic [WIDTH-1:0] src_drive(
    input var logic             blank_i,  // blanking level
    input var logic [WIDTH-1:0] latch_i   // latch contents
  );
    logic [WIDTH-1:0] drive;
    drive = latch_i;
    if (blank_i) begin
      drive = WIDTH'(SLD_RST_ZERO);
    end
    return drive;
  endfunction : src_drive

  // ----------------------------------------------------------------------
  // output drivers
  // ----------------------------------------------------------------------
  // registered so that every pin comes from a flop; blanking and latch
  // changes reach the pins one clock later, far inside the output's own
  // switching time
  logic [WIDTH-1:0] src_q;
  logic [WIDTH-1:0] pd_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // outputs off with pull-downs on, the same safe level as blanking
      src_q <= WIDTH'(SLD_RST_ZERO);
      pd_q  <= ~WIDTH'(SLD_RST_ZERO);
    end else begin
      src_q <= src_drive(blank, latch_q);
      pd_q  <= ~src_drive(blank, latch_q);
    end
  end

  assign src_on = src_q;
  assign pd_on  = pd_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // assertions sleep through reset; each is sampled on the system clock
  // like the logic it guards

  // strobe seen open on two edges in a row
  sequence s_strobe_held;
    strobe ##1 strobe;
  endsequence

  // a new bit shifted in while the latches are open, and the strobe
  // still open one edge later so the latches copy the new register
  sequence s_shift_open;
    s_strobe_held ##0 sclk_rise ##1 strobe;
  endsequence

  // blanking released after a blanked spell
  sequence s_unblank;
    blank ##1 !blank;
  endsequence

  // latches closed and outputs unblanked on two edges in a row
  sequence s_quiet;
    (!strobe && !blank) [*2];
  endsequence

  chk_shift_capture: assert property (
    sclk_rise |=> sreg_q[0] == $past(sdin))
    else $error("first stage did not capture serial data");

  chk_shift_move: assert property (
    sclk_rise |=> sreg_q[WIDTH-1:1] == $past(sreg_q[WIDTH-2:0]))
    else $error("shift register did not move one place");

  chk_sdout_last: assert property (
    sclk_rise |=> sdout == $past(sreg_q[WIDTH-2]))
    else $error("serial out is not the last stage");

  chk_latch_take: assert property (
    strobe |=> latch_q == $past(sreg_q))
    else $error("latch did not take register value");

  chk_latch_track: assert property (
    s_shift_open |=> latch_q == $past(sreg_q))
    else $error("latch stopped tracking under strobe");

  chk_blank_off: assert property (
    blank |=> src_on == '0 && pd_on == '1)
    else $error("blanking did not force outputs off");

  chk_blank_keep: assert property (
    blank && !strobe |=> latch_q == $past(latch_q))
    else $error("blanking changed latch contents");

  chk_out_follow: assert property (
    !blank |=> src_on == $past(latch_q) && pd_on == ~$past(latch_q))
    else $error("outputs do not follow latches");

  chk_latch_hold: assert property (
    !strobe ##1 !strobe |-> $stable(latch_q))
    else $error("latch changed with strobe low");

  chk_shift_idle: assert property (
    !sclk_rise |=> $stable(sreg_q))
    else $error("shift register moved without a serial clock rise");

  chk_drive_opposite: assert property (
    src_on == ~pd_on)
    else $error("source and pull-down of an output not opposite");

  chk_unblank_back: assert property (
    s_unblank |=> src_on == $past(latch_q))
    else $error("outputs did not return to latches after blanking");

  chk_out_steady: assert property (
    s_quiet |=> $stable(src_on))
    else $error("outputs moved with latches closed");

  // ----------------------------------------------------------------------
  // cascade walk check
  // ----------------------------------------------------------------------
  // follows one bit from the input to the serial output: it must come out
  // after exactly one rise per stage, which pins down the register length
  localparam int unsigned WALK_W = $clog2(WIDTH + 1);

  logic [WALK_W-1:0] walk_cnt_q;
  logic              walk_bit_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      walk_cnt_q <= '0;
      walk_bit_q <= 1'b0;
    end else if (sclk_rise) begin
      if (walk_cnt_q == '0 || walk_cnt_q == WALK_W'(WIDTH)) begin
        walk_cnt_q <= WALK_W'(1);
        walk_bit_q <= sdin;
      end else begin
        walk_cnt_q <= walk_cnt_q + WALK_W'(1);
      end
    end
  end

  chk_cascade_walk: assert property (
    walk_cnt_q == WALK_W'(WIDTH) |-> sdout == walk_bit_q)
    else $error("bit left the register after the wrong count");

endmodule : sld_top
`default_nettype wire

/* File: hw/sld_pkg.sv */
package sld_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned SLD_WIDTH = 20;

  // ----------------------------------------------------------------------
  // timing of the controller side, in ns and system clock cycles
  // ----------------------------------------------------------------------
  localparam int unsigned SLD_SYS_CLK_NS     = 4;
  localparam int unsigned SLD_SCLK_MAX_MHZ   = 10;
  localparam int unsigned SLD_SCLK_HIGH_NS   = 50;
  localparam int unsigned SLD_STROBE_SU_NS   = 100;
  localparam int unsigned SLD_STROBE_HIGH_NS = 50;
  // least times round up to whole cycles
  localparam int unsigned SLD_SCLK_HIGH_CYC   =
    (SLD_SCLK_HIGH_NS + SLD_SYS_CLK_NS - 1) / SLD_SYS_CLK_NS;
  localparam int unsigned SLD_STROBE_SU_CYC   =
    (SLD_STROBE_SU_NS + SLD_SYS_CLK_NS - 1) / SLD_SYS_CLK_NS;
  localparam int unsigned SLD_STROBE_HIGH_CYC =
    (SLD_STROBE_HIGH_NS + SLD_SYS_CLK_NS - 1) / SLD_SYS_CLK_NS;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [SLD_WIDTH-1:0] SLD_RST_ZERO = 20'h00000;

endpackage : sld_pkg

/* File: tb/sld_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
module sld_ctl
  import sld_pkg::*;
(
  input  wire logic clk,     // system clock
  output var  logic sclk,    // serial clock
  output var  logic sdin,    // serial data
  output var  logic strobe,  // latch transfer
  output var  logic blank    // blanking
);
  // ------------------------------------------------------------
  // controller timing
  // ------------------------------------------------------------
  localparam int SCLK_CYC = 1000 / SLD_SCLK_MAX_MHZ / SLD_SYS_CLK_NS;
  initial begin
    sclk   = 1'b0;
    sdin   = 1'b0;
    strobe = 1'b0;
    blank  = 1'b0;
  end
  // sdin flips once its hold has run out, so no stale level lingers
  task automatic send(input logic [SLD_WIDTH-1:0] w);
    for (int i = SLD_WIDTH - 1; i >= 0; i--) begin
      @(posedge clk);
      sdin <= w[i];
      repeat (SCLK_CYC - SLD_SCLK_HIGH_CYC) @(posedge clk);
      sclk <= 1'b1;
      repeat (SLD_SCLK_HIGH_CYC) @(posedge clk);
      sclk <= 1'b0;
      sdin <= ~w[i];
    end
  endtask : send
  task automatic set_strobe(input logic s);
    repeat (SLD_STROBE_SU_CYC) @(posedge clk);
    strobe <= s;
  endtask : set_strobe
  task automatic pulse();
    set_strobe(1'b1);
    repeat (SLD_STROBE_HIGH_CYC) @(posedge clk);
    strobe <= 1'b0;
  endtask : pulse
  task automatic set_blank(input logic b);
    @(posedge clk);
    blank <= b;
  endtask : set_blank
endmodule : sld_ctl
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  import sld_pkg::*;
  logic                 clk       = 1'b0;
  logic                 rst_n     = 1'b0;
  int                   err_count = 0;
  int                   checks    = 0;
  wire                  sclk, sdin, strobe, blank, sdout;
  wire [SLD_WIDTH-1:0]  src_on, pd_on;
  localparam logic [SLD_WIDTH-1:0] A = 20'h5a3c9, B = 20'ha5c36;
  localparam logic [SLD_WIDTH-1:0] C = 20'h0f0f1;
  always #2 clk = ~clk;
  sld_top uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sdin(sdin),
    .strobe(strobe), .blank(blank), .sdout(sdout), .src_on(src_on),
    .pd_on(pd_on));
  sld_ctl ctl (.clk(clk), .sclk(sclk), .sdin(sdin), .strobe(strobe),
    .blank(blank));
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic outs(input logic [SLD_WIDTH-1:0] w, input string nm);
    repeat (3) @(posedge clk);
    #1;
    `CHK(nm, w, src_on)
    `CHK(nm, ~w, pd_on)
  endtask : outs
  task automatic t_load();
    ctl.send(A);
    #1 `CHK("sdout", A[19], sdout)
    ctl.pulse();
    outs(A, "load");
  endtask : t_load
  task automatic t_hold();
    ctl.send(B);
    #1 `CHK("sdout", B[19], sdout)
    outs(A, "hold");
  endtask : t_hold
  task automatic t_blank();
    ctl.set_blank(1'b1);
    repeat (3) @(posedge clk);
    #1 `CHK("blank src", 20'h00000, src_on)
    `CHK("blank pd", 20'hfffff, pd_on)
    ctl.set_blank(1'b0);
    outs(A, "unblank");
    ctl.pulse();
    outs(B, "second");
  endtask : t_blank
  // strobe left open while loading, so latches must follow each shift
  task automatic t_track();
    ctl.set_blank(1'b1);
    ctl.set_strobe(1'b1);
    ctl.send(C);
    ctl.set_strobe(1'b0);
    ctl.set_blank(1'b0);
    outs(C, "track");
  endtask : t_track
  // reset in mid-run clears all state, and loading works again after it
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    #1 `CHK("reset src", 20'h00000, src_on)
    `CHK("reset pd", 20'hfffff, pd_on)
    `CHK("reset sdout", 1'b0, sdout)
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    outs(20'h00000, "after reset");
    ctl.send(A);
    ctl.pulse();
    outs(A, "reload");
  endtask : t_reset
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_load();
    t_hold();
    t_blank();
    t_reset();
    t_track();
    report_and_stop();
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
